// ===== logic/tpw_consts.svh
// Named constants for the 8-bit PWM timer block.
`ifndef TPW_CONSTS_SVH
`define TPW_CONSTS_SVH
`define TPW_BOTTOM 8'h00
`define TPW_MAX 8'hFF
`define TPW_WGM_PC_FIX 3'h1
`define TPW_WGM_FAST_FIX 3'h3
`define TPW_WGM_PC_OCRA 3'h5
`define TPW_WGM_FAST_OCRA 3'h7
`define TPW_COM_OFF 2'h0
`define TPW_COM_TOGGLE 2'h1
`define TPW_COM_NONINV 2'h2
`define TPW_COM_INV 2'h3
`define TPW_CS_STOP 3'h0
`define TPW_CS_DIV1 3'h1
`define TPW_CS_DIV8 3'h2
`define TPW_CS_DIV32 3'h3
`define TPW_CS_DIV64 3'h4
`define TPW_CS_DIV128 3'h5
`define TPW_CS_DIV256 3'h6
`define TPW_CS_DIV1024 3'h7
`define TPW_PRE_MAX 10'h3FF
`define TPW_PRE_8 10'h007
`define TPW_PRE_32 10'h01F
`define TPW_PRE_64 10'h03F
`define TPW_PRE_128 10'h07F
`define TPW_PRE_256 10'h0FF
`define TPW_ADDR_CTRL 12'h000
`define TPW_ADDR_CNT 12'h004
`define TPW_ADDR_OCRA 12'h008
`define TPW_ADDR_OCRB 12'h00C
`define TPW_ADDR_STAT 12'h010
`define TPW_ADDR_PORT 12'h014
`define TPW_F_WGM_LO 0
`define TPW_F_CS_LO 4
`define TPW_F_COMA_LO 8
`define TPW_F_COMB_LO 10
`define TPW_F_ASYNC 12
`define TPW_F_TOV 0
`define TPW_F_OCFA 1
`define TPW_F_OCFB 2
`define TPW_F_DIR_A 0
`define TPW_F_DIR_B 1
`define TPW_F_PORT_A 2
`define TPW_F_PORT_B 3
`endif

// ===== logic/tpw_pkg.sv
// Types shared by the 8-bit PWM timer block.
package tpw_pkg;
    typedef enum logic [0:0] {
        TPW_UP = 1'b0,
        TPW_DOWN = 1'b1
    } tpw_dir_e;

    typedef struct packed {
        logic [2:0] wgm;
        logic [2:0] cs;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic async_sel;
    } tpw_ctrl_s;

    typedef struct packed {
        logic dir_a;
        logic dir_b;
        logic port_a;
        logic port_b;
    } tpw_port_s;
endpackage

// ===== logic/tpw_timer.sv
// 8-bit timer with fast and phase-correct PWM on two compare channels.
`timescale 1ns/10ps
`include "tpw_consts.svh"

// How it works
// - Mode select 3 or 7 runs single-slope fast PWM.
// - Fast PWM top is 0xFF in mode 3, compare A in mode 7.
// - Fast PWM counts up to top, clears on the next tick.
// - Fast non-inverting clears on match, sets at top to bottom.
// - Output mode two is non-inverted, three is inverted PWM.
// - Fast PWM sets the overflow flag on the tick that wraps the counter from top to bottom.
// - Fast PWM with top 0xFF repeats every 256 ticks.
// - Tick prescaler divides by 1, 8, 32, 64, 128, 256 or 1024.
// - Compare A at bottom gives a spike, at max a constant level.
// - Fast PWM output mode 1 toggles on each compare A match.
// - Compare values are double buffered, updated at the top.
// - Mode select 1 or 5 runs dual-slope phase-correct PWM.
// - Phase-correct counter stays at top for exactly one tick.
// - Phase-correct non-inverting clears on up-match, sets on down-match.
// - Phase-correct sets the overflow flag on reaching bottom.
// - Phase-correct with top 0xFF repeats every 510 ticks.
// - Phase-correct non-inverting compare at bottom holds low, at max holds high.
// - Phase-correct output at max equals the down-counting match result.
// - A missed up-match still gives the symmetric transition at bottom.
// - The compare output drives the pin only when direction is output.
// - The tick enables the clock, or the oscillator replaces it.
// - Output mode 0 does nothing and leaves normal port control.
// - A software counter write blocks matches for the next tick.
module tpw_timer (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic osc_clk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic compare_output_a_pin,
    output logic compare_output_a_oe_b,
    output logic compare_output_b_pin,
    output logic compare_output_b_oe_b
);
    tpw_pkg::tpw_ctrl_s ctrl;
    tpw_pkg::tpw_port_s port;
    tpw_pkg::tpw_dir_e dir;
    logic [7:0] counter_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] compare_buf_a;
    logic [7:0] compare_buf_b;
    logic compare_output_a;
    logic compare_output_b;
    logic overflow_flag;
    logic compare_a_flag;
    logic compare_b_flag;
    logic [9:0] prescale;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic timer_tick;
    logic block_match;
    logic wr_en;
    logic rd_en;
    logic cnt_wr;
    logic is_fast;
    logic is_pc;
    logic [7:0] top;
    logic match_a;
    logic match_b;
    logic [7:0] next_count;
    tpw_pkg::tpw_dir_e next_dir;

    // ***********************************************************
    // Register bus
    // ***********************************************************
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    // Read data is captured in the setup cycle, so a flop holds it steady
    // through the access phase while pready is high.
    assign rd_en = psel && !penable && !pwrite;
    assign cnt_wr = wr_en && paddr == `TPW_ADDR_CNT;

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = a == `TPW_ADDR_CTRL || a == `TPW_ADDR_CNT ||
            a == `TPW_ADDR_OCRA || a == `TPW_ADDR_OCRB ||
            a == `TPW_ADDR_STAT || a == `TPW_ADDR_PORT;
    endfunction

    assign pslverr = psel && penable && !known_addr(paddr);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= '0;
            port <= '0;
            compare_buf_a <= `TPW_BOTTOM;
            compare_buf_b <= `TPW_BOTTOM;
        end else if (wr_en) begin
            unique case (paddr)
                `TPW_ADDR_CTRL: begin
                    ctrl.wgm <= pwdata[`TPW_F_WGM_LO +: 3];
                    ctrl.cs <= pwdata[`TPW_F_CS_LO +: 3];
                    ctrl.com_a <= pwdata[`TPW_F_COMA_LO +: 2];
                    ctrl.com_b <= pwdata[`TPW_F_COMB_LO +: 2];
                    ctrl.async_sel <= pwdata[`TPW_F_ASYNC];
                end
                `TPW_ADDR_OCRA: compare_buf_a <= pwdata[7:0];
                `TPW_ADDR_OCRB: compare_buf_b <= pwdata[7:0];
                `TPW_ADDR_PORT: begin
                    port.dir_a <= pwdata[`TPW_F_DIR_A];
                    port.dir_b <= pwdata[`TPW_F_DIR_B];
                    port.port_a <= pwdata[`TPW_F_PORT_A];
                    port.port_b <= pwdata[`TPW_F_PORT_B];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= '0;
            unique case (paddr)
                `TPW_ADDR_CTRL: begin
                    prdata[`TPW_F_WGM_LO +: 3] <= ctrl.wgm;
                    prdata[`TPW_F_CS_LO +: 3] <= ctrl.cs;
                    prdata[`TPW_F_COMA_LO +: 2] <= ctrl.com_a;
                    prdata[`TPW_F_COMB_LO +: 2] <= ctrl.com_b;
                    prdata[`TPW_F_ASYNC] <= ctrl.async_sel;
                end
                `TPW_ADDR_CNT: prdata[7:0] <= counter_value;
                `TPW_ADDR_OCRA: prdata[7:0] <= compare_buf_a;
                `TPW_ADDR_OCRB: prdata[7:0] <= compare_buf_b;
                `TPW_ADDR_STAT: begin
                    prdata[`TPW_F_TOV] <= overflow_flag;
                    prdata[`TPW_F_OCFA] <= compare_a_flag;
                    prdata[`TPW_F_OCFB] <= compare_b_flag;
                end
                `TPW_ADDR_PORT: begin
                    prdata[`TPW_F_DIR_A] <= port.dir_a;
                    prdata[`TPW_F_DIR_B] <= port.dir_b;
                    prdata[`TPW_F_PORT_A] <= port.port_a;
                    prdata[`TPW_F_PORT_B] <= port.port_b;
                end
                default: ;
            endcase
        end
    end

    // ***********************************************************
    // Timer tick
    // ***********************************************************
    // The oscillator is sampled into the clock domain and its rising edge
    // becomes the tick, so the block stays on one clock. The oscillator
    // must run below a quarter of the clock rate.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= osc_clk;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= '0;
        end else if (ctrl.cs == `TPW_CS_STOP) begin
            prescale <= '0;
        end else if (!ctrl.async_sel || (osc_s2 && !osc_s3)) begin
            prescale <= prescale + 10'h001;
        end
    end

    function automatic logic tick_of(input logic [2:0] cs,
                                     input logic [9:0] p);
        unique case (cs)
            `TPW_CS_STOP: tick_of = 1'b0;
            `TPW_CS_DIV1: tick_of = 1'b1;
            `TPW_CS_DIV8: tick_of = (p & `TPW_PRE_8) == `TPW_PRE_8;
            `TPW_CS_DIV32: tick_of = (p & `TPW_PRE_32) == `TPW_PRE_32;
            `TPW_CS_DIV64: tick_of = (p & `TPW_PRE_64) == `TPW_PRE_64;
            `TPW_CS_DIV128: tick_of = (p & `TPW_PRE_128) == `TPW_PRE_128;
            `TPW_CS_DIV256: tick_of = (p & `TPW_PRE_256) == `TPW_PRE_256;
            `TPW_CS_DIV1024: tick_of = p == `TPW_PRE_MAX;
        endcase
    endfunction

    assign timer_tick = tick_of(ctrl.cs, prescale) &&
        (!ctrl.async_sel || (osc_s2 && !osc_s3));

    // ***********************************************************
    // Counter
    // ***********************************************************
    assign is_fast = ctrl.wgm == `TPW_WGM_FAST_FIX ||
        ctrl.wgm == `TPW_WGM_FAST_OCRA;
    assign is_pc = ctrl.wgm == `TPW_WGM_PC_FIX ||
        ctrl.wgm == `TPW_WGM_PC_OCRA;
    assign top = (ctrl.wgm == `TPW_WGM_FAST_OCRA ||
        ctrl.wgm == `TPW_WGM_PC_OCRA) ? compare_value_a : `TPW_MAX;

    always_comb begin
        next_count = counter_value + 8'h01;
        next_dir = dir;
        if (is_fast) begin
            next_dir = tpw_pkg::TPW_UP;
            if (counter_value == top) begin
                next_count = `TPW_BOTTOM;
            end
        end else if (is_pc) begin
            if (dir == tpw_pkg::TPW_UP && counter_value >= top) begin
                next_dir = tpw_pkg::TPW_DOWN;
                next_count = counter_value - 8'h01;
            end else if (dir == tpw_pkg::TPW_DOWN) begin
                if (counter_value == `TPW_BOTTOM) begin
                    next_dir = tpw_pkg::TPW_UP;
                end else begin
                    next_count = counter_value - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            counter_value <= `TPW_BOTTOM;
            dir <= tpw_pkg::TPW_UP;
        end else if (cnt_wr) begin
            counter_value <= pwdata[7:0];
        end else if (timer_tick) begin
            counter_value <= next_count;
            dir <= next_dir;
        end
    end

    // A counter write arms the blocker until the next tick has passed.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            block_match <= 1'b0;
        end else if (cnt_wr) begin
            block_match <= 1'b1;
        end else if (timer_tick) begin
            block_match <= 1'b0;
        end
    end

    // Buffered values load at top in fast PWM and at top in phase-correct.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_value_a <= `TPW_BOTTOM;
            compare_value_b <= `TPW_BOTTOM;
        end else if (!(is_fast || is_pc) ||
                     (timer_tick && counter_value == top &&
                      dir == tpw_pkg::TPW_UP)) begin
            compare_value_a <= compare_buf_a;
            compare_value_b <= compare_buf_b;
        end
    end

    assign match_a = counter_value == compare_value_a && !block_match;
    assign match_b = counter_value == compare_value_b && !block_match;

    // ***********************************************************
    // Flags
    // ***********************************************************
    // Writing a one to a status bit clears it; a new event the same cycle
    // wins over the clear.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
        end else if (timer_tick && ((is_fast && counter_value == top) ||
                     (is_pc && dir == tpw_pkg::TPW_DOWN &&
                      counter_value == `TPW_BOTTOM + 8'h01))) begin
            overflow_flag <= 1'b1;
        end else if (wr_en && paddr == `TPW_ADDR_STAT &&
                     pwdata[`TPW_F_TOV]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_a_flag <= 1'b0;
            compare_b_flag <= 1'b0;
        end else begin
            if (timer_tick && match_a) begin
                compare_a_flag <= 1'b1;
            end else if (wr_en && paddr == `TPW_ADDR_STAT &&
                         pwdata[`TPW_F_OCFA]) begin
                compare_a_flag <= 1'b0;
            end
            if (timer_tick && match_b) begin
                compare_b_flag <= 1'b1;
            end else if (wr_en && paddr == `TPW_ADDR_STAT &&
                         pwdata[`TPW_F_OCFB]) begin
                compare_b_flag <= 1'b0;
            end
        end
    end

    // ***********************************************************
    // Waveform
    // ***********************************************************
    // Returns the new compare output for one channel on a tick.
    function automatic logic wave(input logic cur, input logic [1:0] com,
                                  input logic match, input logic chan_a,
                                  input logic fast, input logic pc,
                                  input logic at_top, input logic down,
                                  input logic at_bottom,
                                  input logic cmp_max);
        logic inv;
        inv = com == `TPW_COM_INV;
        wave = cur;
        if (com == `TPW_COM_OFF) begin
            wave = cur;
        end else if (com == `TPW_COM_TOGGLE) begin
            if (fast && chan_a && match) begin
                wave = !cur;
            end
        end else if (fast) begin
            if (at_top) begin
                wave = !inv;
            end
            if (match && !(at_top && cmp_max)) begin
                wave = inv;
            end
        end else if (pc) begin
            if (match) begin
                wave = down ? !inv : inv;
            end else if (at_bottom && cmp_max) begin
                wave = inv;
            end else if (at_bottom) begin
                wave = !inv;
            end
        end
    endfunction

    // The slope that follows the tick decides the match: at top a match acts
    // as a down-count match and at bottom as an up-count one, so the extreme
    // compare values give constant levels.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_output_a <= 1'b0;
            compare_output_b <= 1'b0;
        end else if (timer_tick) begin
            compare_output_a <= wave(compare_output_a, ctrl.com_a, match_a,
                1'b1, is_fast, is_pc, counter_value == top,
                next_dir == tpw_pkg::TPW_DOWN,
                counter_value == `TPW_BOTTOM && dir == tpw_pkg::TPW_UP,
                compare_value_a == `TPW_MAX);
            compare_output_b <= wave(compare_output_b, ctrl.com_b, match_b,
                1'b0, is_fast, is_pc, counter_value == top,
                next_dir == tpw_pkg::TPW_DOWN,
                counter_value == `TPW_BOTTOM && dir == tpw_pkg::TPW_UP,
                compare_value_b == `TPW_MAX);
        end
    end

    // The output unit overrides the port latch when its mode is nonzero.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_output_a_pin <= 1'b0;
            compare_output_b_pin <= 1'b0;
            compare_output_a_oe_b <= 1'b1;
            compare_output_b_oe_b <= 1'b1;
        end else begin
            compare_output_a_pin <= (ctrl.com_a != `TPW_COM_OFF) ?
                compare_output_a : port.port_a;
            compare_output_b_pin <= (ctrl.com_b != `TPW_COM_OFF) ?
                compare_output_b : port.port_b;
            compare_output_a_oe_b <= !port.dir_a;
            compare_output_b_oe_b <= !port.dir_b;
        end
    end

    // ***********************************************************
    // Checks
    // ***********************************************************
    a_fast_wrap: assert property (@(posedge clock) disable iff (!rst_b)
        timer_tick && is_fast && counter_value == top && !cnt_wr
        |=> counter_value == `TPW_BOTTOM)
        else $error("fast counter did not wrap after top");
    a_fast_ovf: assert property (@(posedge clock) disable iff (!rst_b)
        timer_tick && is_fast && counter_value == top |=> overflow_flag)
        else $error("overflow flag missed at top");
    a_pc_turn: assert property (@(posedge clock) disable iff (!rst_b)
        timer_tick && is_pc && dir == tpw_pkg::TPW_UP &&
        counter_value == top && !cnt_wr && top != `TPW_BOTTOM
        |=> dir == tpw_pkg::TPW_DOWN && counter_value == $past(top) - 8'h01)
        else $error("phase-correct did not turn at top");
    a_pc_ovf: assert property (@(posedge clock) disable iff (!rst_b)
        timer_tick && is_pc && dir == tpw_pkg::TPW_DOWN &&
        counter_value == 8'h01 && !cnt_wr
        |=> overflow_flag && counter_value == `TPW_BOTTOM)
        else $error("overflow flag missed at bottom");
    a_block_match: assert property (
        @(posedge clock) disable iff (!rst_b)
        cnt_wr |=> !match_a && !match_b)
        else $error("match not blocked after counter write");
    a_pin_dir: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(port.dir_a) |=> !compare_output_a_oe_b)
        else $error("pin not enabled after direction set");
    a_stop_hold: assert property (@(posedge clock) disable iff (!rst_b)
        ctrl.cs == `TPW_CS_STOP && !cnt_wr && $stable(ctrl)
        |=> $stable(counter_value))
        else $error("counter moved while stopped");
    a_fast_clear: assert property (@(posedge clock) disable iff (!rst_b)
        timer_tick && is_fast && ctrl.com_a == `TPW_COM_NONINV && match_a &&
        counter_value != top |=> !compare_output_a)
        else $error("non-inverted output not cleared on match");
endmodule

// ===== verification/tpw_load.sv
// Load model on the two compare output pins of the PWM timer.
`timescale 1ns/10ps
module tpw_load (
    input wire logic pin_a,
    input wire logic oe_a_b,
    input wire logic pin_b,
    input wire logic oe_b_b,
    output logic level_a,
    output logic level_b
);
    // A pull-down holds a released pin low, so stale data never shows.
    assign level_a = oe_a_b ? 1'b0 : pin_a;
    assign level_b = oe_b_b ? 1'b0 : pin_b;
endmodule

// ===== verification/tb.sv
// Self-checking bench for the PWM timer block.
`timescale 1ns/10ps
`include "tpw_consts.svh"
module tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic osc_clk = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, a_pin, a_oe_b, b_pin, b_oe_b;
    logic level_a, level_b, e;
    logic [31:0] q;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int h;
    int p;

    tpw_timer dut (
        .clock(clock),
        .rst_b(rst_b),
        .osc_clk(osc_clk),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .compare_output_a_pin(a_pin),
        .compare_output_a_oe_b(a_oe_b),
        .compare_output_b_pin(b_pin),
        .compare_output_b_oe_b(b_oe_b)
    );

    tpw_load load (
        .pin_a(a_pin),
        .oe_a_b(a_oe_b),
        .pin_b(b_pin),
        .oe_b_b(b_oe_b),
        .level_a(level_a),
        .level_b(level_b)
    );

    initial begin
        forever #20 clock = ~clock;
    end

    // The oscillator is a fifth of the bus clock, inside the allowed ratio.
    initial begin
        forever #100 osc_clk = ~osc_clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Response and read data are taken at the edge that sees pready high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        e = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task cfg(input logic [2:0] m, input logic [1:0] ca, input logic [1:0] cb,
             input logic [7:0] oa, input logic [7:0] ob,
             input logic [2:0] cs, input logic as);
        apb(1'b1, `TPW_ADDR_OCRA, {24'h0, oa});
        apb(1'b1, `TPW_ADDR_OCRB, {24'h0, ob});
        apb(1'b1, `TPW_ADDR_CTRL, {19'h0, as, cb, ca, 1'b0, cs, 1'b0, m});
        apb(1'b1, `TPW_ADDR_CNT, 32'h0);
    endtask

    function logic lvl(input logic ch);
        return ch ? level_b : level_a;
    endfunction

    // Counts in bus clocks from a rising edge: high time, then period.
    task measure(input logic ch);
        h = 0;
        @(posedge clock);
        while (lvl(ch) !== 1'b0) @(posedge clock);
        while (lvl(ch) !== 1'b1) @(posedge clock);
        while (lvl(ch) === 1'b1) begin
            h++;
            @(posedge clock);
        end
        p = h;
        while (lvl(ch) === 1'b0) begin
            p++;
            @(posedge clock);
        end
    endtask

    task pwm(input logic ch, input logic [31:0] eh, input logic [31:0] ep);
        measure(ch);
        check("high_time", h, eh);
        check("period", p, ep);
    endtask

    // A settling span first, since compare values load only at top.
    task steady(input logic ch, input logic ev);
        int bad;
        bad = 0;
        repeat (1100) @(posedge clock);
        repeat (600) begin
            @(posedge clock);
            if (lvl(ch) !== ev) bad++;
        end
        check("steady_level", bad, 32'h0);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 70000) begin
            err_count++;
            stop_test();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, `TPW_ADDR_CTRL, 32'h0);
        check("ctrl_reset", q, 32'h0);
        check("pready", {31'h0, pready}, 32'h1);
        check("oe_a_reset", {31'h0, a_oe_b}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped_err", {31'h0, e}, 32'h1);
        check("unmapped_data", q, 32'h0);
        apb(1'b1, `TPW_ADDR_PORT, 32'h5);
        repeat (3) @(posedge clock);
        check("port_level", {31'h0, level_a}, 32'h1);
        apb(1'b1, `TPW_ADDR_PORT, 32'h4);
        repeat (3) @(posedge clock);
        check("oe_a_off", {31'h0, a_oe_b}, 32'h1);
        apb(1'b1, `TPW_ADDR_PORT, 32'h3);
        $display("test reset and port done");
        cfg(3'h3, 2'h2, 2'h3, 8'h80, 8'h40, 3'h1, 1'b0);
        pwm(1'b0, 32'h81, 32'h100);
        pwm(1'b1, 32'hBF, 32'h100);
        cfg(3'h3, 2'h2, 2'h3, 8'h80, 8'h40, 3'h2, 1'b0);
        pwm(1'b0, 32'h408, 32'h800);
        cfg(3'h3, 2'h2, 2'h3, 8'h80, 8'h40, 3'h3, 1'b0);
        pwm(1'b0, 32'h1020, 32'h2000);
        $display("test fast pwm done");
        cfg(3'h1, 2'h2, 2'h3, 8'h80, 8'h40, 3'h1, 1'b0);
        pwm(1'b0, 32'h100, 32'h1FE);
        pwm(1'b1, 32'h17E, 32'h1FE);
        $display("test phase correct done");
        cfg(3'h7, 2'h1, 2'h2, 8'h3F, 8'h1F, 3'h1, 1'b0);
        pwm(1'b0, 32'h40, 32'h80);
        pwm(1'b1, 32'h20, 32'h40);
        cfg(3'h5, 2'h0, 2'h2, 8'h3F, 8'h1F, 3'h1, 1'b0);
        pwm(1'b1, 32'h3E, 32'h7E);
        $display("test variable top done");
        cfg(3'h3, 2'h2, 2'h0, 8'h00, 8'h00, 3'h1, 1'b0);
        pwm(1'b0, 32'h1, 32'h100);
        cfg(3'h3, 2'h2, 2'h0, 8'hFF, 8'h00, 3'h1, 1'b0);
        steady(1'b0, 1'b1);
        cfg(3'h1, 2'h2, 2'h0, 8'h00, 8'h00, 3'h1, 1'b0);
        steady(1'b0, 1'b0);
        cfg(3'h1, 2'h2, 2'h0, 8'hFF, 8'h00, 3'h1, 1'b0);
        steady(1'b0, 1'b1);
        cfg(3'h1, 2'h3, 2'h0, 8'hFF, 8'h00, 3'h1, 1'b0);
        steady(1'b0, 1'b0);
        $display("test extremes done");
        cfg(3'h0, 2'h0, 2'h0, 8'h10, 8'h00, 3'h0, 1'b0);
        apb(1'b1, `TPW_ADDR_CNT, 32'h10);
        apb(1'b1, `TPW_ADDR_STAT, 32'h7);
        apb(1'b1, `TPW_ADDR_CTRL, 32'h10);
        apb(1'b0, `TPW_ADDR_STAT, 32'h0);
        check("match_blocked", {31'h0, q[1]}, 32'h0);
        $display("test match blocking done");
        cfg(3'h3, 2'h2, 2'h0, 8'h80, 8'h00, 3'h0, 1'b0);
        apb(1'b1, `TPW_ADDR_STAT, 32'h7);
        apb(1'b0, `TPW_ADDR_STAT, 32'h0);
        check("flag_clear", q, 32'h0);
        cfg(3'h3, 2'h2, 2'h0, 8'h80, 8'h00, 3'h1, 1'b0);
        repeat (300) @(posedge clock);
        apb(1'b0, `TPW_ADDR_STAT, 32'h0);
        check("fast_overflow", {31'h0, q[0]}, 32'h1);
        cfg(3'h1, 2'h2, 2'h0, 8'h80, 8'h00, 3'h0, 1'b0);
        apb(1'b1, `TPW_ADDR_STAT, 32'h7);
        cfg(3'h1, 2'h2, 2'h0, 8'h80, 8'h00, 3'h1, 1'b0);
        repeat (600) @(posedge clock);
        apb(1'b0, `TPW_ADDR_STAT, 32'h0);
        check("pc_overflow", {31'h0, q[0]}, 32'h1);
        $display("test overflow flag done");
        cfg(3'h3, 2'h2, 2'h0, 8'h80, 8'h00, 3'h1, 1'b1);
        measure(1'b0);
        check("async_period", {31'h0, p >= 1275 && p <= 1285}, 32'h1);
        $display("test oscillator clock done");
        stop_test();
    end
endmodule
